// ---- bench/pmc_cpu_model.sv ----
// CPU core model: executes mode instructions and raises interrupts
module pmc_cpu_model
    import pmc_pkg::*;
(
    input  wire logic clk_sys,
    output pmc_cpu_s  cpu,
    output logic      irq_any,
    output logic      irq_rtc,
    output logic      irq_can_i2c
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        cpu         = '0;
        irq_any     = 1'b0;
        irq_rtc     = 1'b0;
        irq_can_i2c = 1'b0;
    end
    task automatic exec(input logic pd, input int busy, input logic rdy);
        @(posedge clk_sys);
        cpu.idle_req      <= !pd;
        cpu.pd_req        <= pd;
        cpu.bus_busy      <= (busy > 0);
        cpu.last_rdy_seen <= rdy;
        @(posedge clk_sys);
        cpu.idle_req      <= 1'b0;
        cpu.pd_req        <= 1'b0;
        repeat (busy) @(posedge clk_sys);
        cpu.bus_busy      <= 1'b0;
    endtask
    task automatic pulse(input int w);
        @(posedge clk_sys);
        irq_any     <= (w == 0);
        irq_rtc     <= (w == 1);
        irq_can_i2c <= (w == 2);
        @(posedge clk_sys);
        irq_any     <= 1'b0;
        irq_rtc     <= 1'b0;
        irq_can_i2c <= 1'b0;
    endtask
endmodule

// ---- bench/pmc_power_mode_control_chk.sv ----
// Checker of the power mode controller port timing
module pmc_power_mode_control_chk
    import pmc_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire pmc_cpu_s    cpu,
    input wire logic        irq_any,
    input wire logic        irq_rtc,
    input wire logic        irq_can_i2c,
    input wire logic        reset_input_pin_n,
    input wire pmc_ctl_s    ctl,
    input wire logic        entry_refused,
    input wire logic        wake_pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    // Shadow of the variant bit, as the checker cannot read registers
    logic var_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            var_q <= 1'b0;
        end else if (reg_wr && reg_addr == PMC_OFF_CTRL) begin
            var_q <= reg_wdata[PMC_CTRL_VARIANT_BIT];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    chk_clk_stop_cpu: assert property (
        ctl.clk_stop |-> ctl.cpu_stop) else $error("clock off, cpu on");
    chk_drain_first: assert property (
        $rose(ctl.cpu_stop) |-> !$past(cpu.bus_busy))
        else $error("stopped during a bus transfer");
    chk_refuse_run: assert property (
        entry_refused |-> !ctl.cpu_stop && !$past(entry_refused))
        else $error("refusal while stopped");
    chk_idle_wake: assert property (
        ctl.cpu_stop && !ctl.clk_stop && irq_any |=>
        !ctl.cpu_stop && wake_pulse) else $error("idle not left");
    chk_wake_resume: assert property (
        wake_pulse |-> !ctl.cpu_stop && $past(ctl.cpu_stop))
        else $error("wake pulse without exit");
    chk_prot_hold: assert property (
        (reset_input_pin_n [*6]) ##0 (ctl.clk_stop && !var_q) |=>
        ctl.clk_stop) else $error("protected mode left");
    chk_int_wake: assert property (
        ctl.clk_stop && var_q && (irq_rtc || irq_can_i2c) |=>
        wake_pulse && !ctl.clk_stop) else $error("no interrupt exit");
    chk_osc_in_pd: assert property (
        ctl.main_osc_stop |-> ctl.clk_stop && ctl.cpu_stop)
        else $error("oscillator off outside power-down");
    chk_rdata_quiet: assert property (
        !$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
endmodule

bind pmc_power_mode_control pmc_power_mode_control_chk u_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu(cpu), .irq_any(irq_any),
    .irq_rtc(irq_rtc), .irq_can_i2c(irq_can_i2c),
    .reset_input_pin_n(reset_input_pin_n), .ctl(ctl),
    .entry_refused(entry_refused), .wake_pulse(wake_pulse)
);

// ---- bench/pmc_power_mode_control_tb.sv ----
// Testbench for the power mode controller
`define CK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    err_count++; $display("wrong value %s exp %0h got %0h", n, e, g); \
    end end
module pmc_power_mode_control_tb
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic        nmi_n = 1'b1;
    logic        pin_rst_n = 1'b1;
    logic [7:0]  fx = 8'h00;
    logic        lp = 1'b0;
    logic [15:0] rdata;
    pmc_cpu_s    cpu;
    pmc_ctl_s    ctl;
    logic        irq_any, irq_rtc, irq_can, refused, wake, irq;
    int          err_count = 0;
    int          samples_checked = 0;
    localparam logic [3:0] ADR [6] = '{PMC_OFF_CTRL, PMC_OFF_IRQST,
        PMC_OFF_MASK, PMC_OFF_FXEN, PMC_OFF_FXPOL, 4'hF};
    always #5 clk_sys = ~clk_sys;
    pmc_cpu_model u_cpu (.clk_sys(clk_sys), .cpu(cpu), .irq_any(irq_any),
        .irq_rtc(irq_rtc), .irq_can_i2c(irq_can));
    pmc_power_mode_control dut (.clk_sys(clk_sys), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(rdata), .cpu(cpu), .irq_any(irq_any),
        .irq_rtc(irq_rtc), .irq_can_i2c(irq_can), .nmi_n_pin(nmi_n),
        .reset_input_pin_n(pin_rst_n), .fast_external_interrupt_pin(fx),
        .lp_osc_running(lp), .ctl(ctl), .entry_refused(refused),
        .wake_pulse(wake), .irq(irq));
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        `CK("reg_rdata", e, rdata)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic enter(input logic pd, input logic rdy);
        u_cpu.exec(pd, 0, rdy);
        cyc(1);
    endtask
    // Pins pass a synchroniser, so exits take a few cycles
    task automatic wait_run();
        for (int i = 0; i < 12 && ctl.cpu_stop !== 1'b0; i++) begin
            cyc(1);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #50us;
        err_count++;
        end_sim();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        cyc(8);
        `CK("ctl", 4'h0, ctl)
        for (int i = 0; i < 6; i++) begin
            rd(ADR[i], 16'h0000);
        end
        rd(PMC_OFF_STATUS, 16'h0030);
        $display("test reset done");
        wr(PMC_OFF_MASK, 16'h000F);
        enter(1'b0, 1'b1);
        `CK("cpu_stop", 1'b1, ctl.cpu_stop)
        `CK("clk_stop", 1'b0, ctl.clk_stop)
        `CK("irq", 1'b1, irq)
        u_cpu.pulse(0);
        #1;
        `CK("wake", 1'b1, wake)
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        rd(PMC_OFF_IRQST, 16'h0005);
        rd(PMC_OFF_IRQST, 16'h0000);
        `CK("irq", 1'b0, irq)
        $display("test idle done");
        wr(PMC_OFF_CTRL, 16'h0008);
        u_cpu.exec(1'b0, 3, 1'b1);
        #1;
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        cyc(1);
        `CK("cpu_stop", 1'b1, ctl.cpu_stop)
        u_cpu.pulse(0);
        rd(PMC_OFF_IRQST, 16'h0005);
        wr(PMC_OFF_MASK, 16'h0000);
        enter(1'b0, 1'b0);
        `CK("refused", 1'b1, refused)
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        `CK("irq", 1'b0, irq)
        rd(PMC_OFF_IRQST, 16'h0008);
        $display("test drain done");
        wr(PMC_OFF_CTRL, 16'h0001);
        enter(1'b1, 1'b1);
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        nmi_n <= 1'b0;
        cyc(8);
        enter(1'b1, 1'b1);
        `CK("clk_stop", 1'b1, ctl.clk_stop)
        for (int w = 0; w < 3; w++) begin
            u_cpu.pulse(w);
        end
        cyc(4);
        `CK("clk_stop", 1'b1, ctl.clk_stop)
        pin_rst_n <= 1'b0;
        wait_run();
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        pin_rst_n <= 1'b1;
        nmi_n     <= 1'b1;
        cyc(8);
        rd(PMC_OFF_IRQST, 16'h000E);
        $display("test protected done");
        wr(PMC_OFF_CTRL, 16'h0025);
        wr(PMC_OFF_FXEN, 16'h0001);
        wr(PMC_OFF_FXPOL, 16'h0001);
        fx[0] <= 1'b1;
        cyc(8);
        enter(1'b1, 1'b1);
        `CK("cpu_stop", 1'b0, ctl.cpu_stop)
        fx[0] <= 1'b0;
        cyc(8);
        for (int k = 0; k < 4; k++) begin
            enter(1'b1, 1'b1);
            `CK("clk_stop", 1'b1, ctl.clk_stop)
            `CK("osc_stop", 1'b0, ctl.main_osc_stop)
            if (k < 2) begin
                u_cpu.pulse(k + 1);
            end else if (k == 2) begin
                fx[0] <= 1'b1;
                cyc(1);
                fx[0] <= 1'b0;
                cyc(8);
                `CK("clk_stop", 1'b1, ctl.clk_stop)
                fx[0] <= 1'b1;
                cyc(4);
                fx[0] <= 1'b0;
            end else begin
                pin_rst_n <= 1'b0;
            end
            wait_run();
            `CK("cpu_stop", 1'b0, ctl.cpu_stop)
            pin_rst_n <= 1'b1;
            cyc(8);
        end
        $display("test interruptible done");
        lp <= 1'b1;
        cyc(8);
        `CK("rtc_on_lp", 1'b1, ctl.rtc_on_lp)
        enter(1'b1, 1'b1);
        `CK("osc_stop", 1'b1, ctl.main_osc_stop)
        u_cpu.pulse(1);
        wait_run();
        lp <= 1'b0;
        cyc(8);
        `CK("rtc_on_lp", 1'b1, ctl.rtc_on_lp)
        wr(PMC_OFF_CTRL, 16'h0027);
        cyc(2);
        `CK("rtc_on_lp", 1'b0, ctl.rtc_on_lp)
        $display("test oscillator done");
        end_sim();
    end
endmodule

// ---- rtl/pmc_pkg.sv ----
// Package for the power mode controller: offsets, fields, states, carriers
package pmc_pkg;

    localparam logic [3:0] PMC_OFF_CTRL   = 4'h0;
    localparam logic [3:0] PMC_OFF_STATUS = 4'h1;
    localparam logic [3:0] PMC_OFF_IRQST  = 4'h2;
    localparam logic [3:0] PMC_OFF_MASK   = 4'h3;
    localparam logic [3:0] PMC_OFF_FXEN   = 4'h4;
    localparam logic [3:0] PMC_OFF_FXPOL  = 4'h5;

    // Control register fields
    localparam int PMC_CTRL_VARIANT_BIT  = 5;
    localparam int PMC_CTRL_REGOFF_BIT   = 0;
    localparam int PMC_CTRL_LPDIS_BIT    = 1;
    localparam int PMC_CTRL_RTCEN_BIT    = 2;
    localparam int PMC_CTRL_RDYEN_BIT    = 3;

    // Event bits in status / mask
    localparam int PMC_EV_IDLE_BIT   = 0;
    localparam int PMC_EV_PD_BIT     = 1;
    localparam int PMC_EV_WAKE_BIT   = 2;
    localparam int PMC_EV_REFUSE_BIT = 3;

    localparam logic [15:0] PMC_CTRL_RST = 16'h0000;
    localparam logic [7:0]  PMC_MASK_RST = 8'h00;
    localparam logic [7:0]  PMC_FX_RST   = 8'h00;

    localparam int PMC_FX_MIN_NS   = 40;
    localparam int PMC_CLK_MHZ     = 100;
    localparam int PMC_FX_MIN_CYC  =
        (PMC_FX_MIN_NS * PMC_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        PMC_RUN     = 3'b000,
        PMC_DRAIN   = 3'b001,
        PMC_IDLE    = 3'b010,
        PMC_PD_PROT = 3'b011,
        PMC_PD_INT  = 3'b100
    } pmc_state_e;

    typedef struct packed {
        logic       idle_req;
        logic       pd_req;
        logic       bus_busy;
        logic       last_rdy_seen;
    } pmc_cpu_s;

    typedef struct packed {
        logic       cpu_stop;
        logic       clk_stop;
        logic       main_osc_stop;
        logic       rtc_on_lp;
    } pmc_ctl_s;

endpackage

// ---- rtl/pmc_power_mode_control.sv ----
// Power mode controller: idle and power-down sequencing with wake-up logic
// Function
// - Idle instruction stops the CPU; peripherals keep their clock.
// - Any interrupt request ends idle, serviced or not.
// - After idle exit and return, CPU resumes at the next instruction.
// - Power-down stops internal clock and all units, watchdog included.
// - External bus transaction finishes before idle or power-down begins.
// - Refuse entry if ready enabled but not seen on last access.
// - Variant bit five clear selects protected power-down.
// - Protected power-down entered only while the NMI pin is low.
// - Protected power-down leaves only on external reset pin.
// - Variant bit five set selects interruptible power-down.
// - Interruptible entry only when enabled fast inputs are all inactive.
// - Interruptible exit on reset, fast input, RTC, CAN or I2C interrupt.
// - With 32 kHz running, main oscillator stops; RTC counts on 32 kHz.
// - Low-power oscillator adopted once detected, kept unless disabled.
// - Only main oscillator running: it keeps running through power-down if the RTC enable bit is set, else it stops.
module pmc_power_mode_control
    import pmc_pkg::*;
#(
    parameter int NFX = 8
) (
    input  wire logic           clk_sys,
    input  wire logic           rst,
    // Register port
    input  wire logic [3:0]     reg_addr,
    input  wire logic [15:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic      [15:0]    reg_rdata,
    // CPU side
    input  wire pmc_cpu_s       cpu,
    input  wire logic           irq_any,
    input  wire logic           irq_rtc,
    input  wire logic           irq_can_i2c,
    // Pins
    input  wire logic           nmi_n_pin,
    input  wire logic           reset_input_pin_n,
    input  wire logic [NFX-1:0] fast_external_interrupt_pin,
    input  wire logic           lp_osc_running,
    // Controls
    output pmc_ctl_s            ctl,
    output logic                entry_refused,
    output logic                wake_pulse,
    output logic                irq
);
    logic [15:0]    system_configuration_register_q;
    logic [7:0]     irq_status_q;
    logic [7:0]     irq_mask_q;
    logic [NFX-1:0] fx_en_q;
    logic [NFX-1:0] fx_pol_q;
    pmc_state_e     state_q;
    pmc_state_e     state_d;
    logic           pend_pd_q;
    logic           nmi_low_q;
    logic           fx_quiet_q;
    logic           lp_ref_q;
    logic [NFX-1:0] fx_sync;
    logic           nmi_low_sync;
    logic           reset_input_pin_low_sync;
    logic           nmi_n_sync;
    logic           reset_input_pin_n_sync;
    logic           lp_sync;
    logic [7:0]     fx_cnt_q;
    logic           fx_hit_q;
    logic           wake_q;
    logic           refuse_q;
    pmc_ctl_s       ctl_q;
    logic [15:0]    rdata_q;

    logic variant_int;
    logic req_any;
    logic entry_ok;
    logic fx_active_any;
    logic pd_wake;
    logic [7:0] ev_set;
    logic wake_now;
    logic refuse_now;
    logic irqst_rd;

    // Pin inputs cross into the clock domain; active-low pins go in
    // inverted so a cleared synchroniser reads idle, not a false reset
    pmc_sync3 #(.W(NFX + 3)) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     ({fast_external_interrupt_pin, ~nmi_n_pin,
                   ~reset_input_pin_n, lp_osc_running}),
        .dout    ({fx_sync, nmi_low_sync, reset_input_pin_low_sync, lp_sync})
    );

    assign nmi_n_sync   = ~nmi_low_sync;
    assign reset_input_pin_n_sync = ~reset_input_pin_low_sync;

    function automatic logic fx_asserted(input logic [NFX-1:0] lvl,
                                         input logic [NFX-1:0] en,
                                         input logic [NFX-1:0] pol);
        fx_asserted = |((lvl ~^ pol) & en);
    endfunction

    // State groups decoded in several places
    function automatic logic in_pd(input pmc_state_e st);
        in_pd = (st == PMC_PD_PROT) || (st == PMC_PD_INT);
    endfunction

    function automatic logic in_halt(input pmc_state_e st);
        in_halt = (st != PMC_RUN) && (st != PMC_DRAIN);
    endfunction

    assign variant_int = system_configuration_register_q[PMC_CTRL_VARIANT_BIT];
    assign req_any = cpu.idle_req | cpu.pd_req;
    assign fx_active_any = fx_asserted(fx_sync, fx_en_q, fx_pol_q);

    always_comb begin
        entry_ok = 1'b1;
        if (system_configuration_register_q[PMC_CTRL_RDYEN_BIT] &&
            !cpu.last_rdy_seen) begin
            entry_ok = 1'b0;
        end
        if (pend_pd_q) begin
            if (!variant_int && !nmi_low_q) begin
                entry_ok = 1'b0;
            end
            if (variant_int && !fx_quiet_q) begin
                entry_ok = 1'b0;
            end
        end
    end

    // Any gap restarts the count, so short glitches never wake
    // minimum assert width qualified by count
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fx_cnt_q <= 8'h00;
            fx_hit_q <= 1'b0;
        end else if (state_q == PMC_PD_INT && fx_active_any) begin
            if (fx_cnt_q < 8'(PMC_FX_MIN_CYC)) begin
                fx_cnt_q <= fx_cnt_q + 8'h01;
            end
            fx_hit_q <= (fx_cnt_q + 8'h01 >= 8'(PMC_FX_MIN_CYC));
        end else begin
            fx_cnt_q <= 8'h00;
            fx_hit_q <= 1'b0;
        end
    end

    assign pd_wake = fx_hit_q | irq_rtc | irq_can_i2c;

    assign wake_now   = in_halt(state_q) && (state_d == PMC_RUN);
    assign refuse_now = (state_q == PMC_DRAIN) && !cpu.bus_busy && !entry_ok;
    assign irqst_rd   = reg_rd && (reg_addr == PMC_OFF_IRQST);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PMC_RUN: begin
                if (req_any) begin
                    state_d = PMC_DRAIN;
                end
            end
            PMC_DRAIN: begin
                if (!cpu.bus_busy) begin
                    if (!entry_ok) begin
                        state_d = PMC_RUN;
                    end else if (!pend_pd_q) begin
                        state_d = PMC_IDLE;
                    end else if (variant_int) begin
                        state_d = PMC_PD_INT;
                    end else begin
                        state_d = PMC_PD_PROT;
                    end
                end
            end
            PMC_IDLE: begin
                if (irq_any) begin
                    state_d = PMC_RUN;
                end
            end
            PMC_PD_PROT: begin
                if (!reset_input_pin_n_sync) begin
                    state_d = PMC_RUN;
                end
            end
            PMC_PD_INT: begin
                if (!reset_input_pin_n_sync || pd_wake) begin
                    state_d = PMC_RUN;
                end
            end
            default: begin
                state_d = PMC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= PMC_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    // pin levels taken when the instruction executes
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_pd_q  <= 1'b0;
            nmi_low_q  <= 1'b0;
            fx_quiet_q <= 1'b0;
        end else if (state_q == PMC_RUN && req_any) begin
            pend_pd_q  <= cpu.pd_req;
            nmi_low_q  <= !nmi_n_sync;
            fx_quiet_q <= !fx_active_any;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lp_ref_q <= 1'b0;
        end else if (system_configuration_register_q[PMC_CTRL_LPDIS_BIT]) begin
            lp_ref_q <= 1'b0;
        end else if (lp_sync) begin
            lp_ref_q <= 1'b1;
        end
    end

    // Outputs registered; CPU held until wake so it resumes in order
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctl_q <= '0;
        end else begin
            ctl_q.cpu_stop <= in_halt(state_d);
            ctl_q.clk_stop <= in_pd(state_d);
            ctl_q.main_osc_stop <= in_pd(state_d) &&
                (lp_ref_q ||
                 !system_configuration_register_q[PMC_CTRL_RTCEN_BIT]);
            ctl_q.rtc_on_lp <= lp_ref_q;
        end
    end

    // One-cycle event pulses towards the CPU
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wake_q   <= 1'b0;
            refuse_q <= 1'b0;
        end else begin
            wake_q   <= wake_now;
            refuse_q <= refuse_now;
        end
    end

    assign ctl           = ctl_q;
    assign wake_pulse    = wake_q;
    assign entry_refused = refuse_q;

    always_comb begin
        ev_set = 8'h00;
        ev_set[PMC_EV_IDLE_BIT]   = (state_q == PMC_DRAIN) &&
                                    (state_d == PMC_IDLE);
        ev_set[PMC_EV_PD_BIT]     = (state_q == PMC_DRAIN) &&
                                    in_pd(state_d);
        ev_set[PMC_EV_WAKE_BIT]   = wake_now;
        ev_set[PMC_EV_REFUSE_BIT] = refuse_now;
    end

    // Config registers; regulator-off bit is software's duty before power-down
    // regulator bit held
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            system_configuration_register_q <= PMC_CTRL_RST;
            irq_mask_q <= PMC_MASK_RST;
            fx_en_q    <= NFX'(PMC_FX_RST);
            fx_pol_q   <= NFX'(PMC_FX_RST);
        end else if (reg_wr) begin
            case (reg_addr)
                PMC_OFF_CTRL:  system_configuration_register_q <= reg_wdata;
                PMC_OFF_MASK:  irq_mask_q <= reg_wdata[7:0];
                PMC_OFF_FXEN:  fx_en_q    <= reg_wdata[NFX-1:0];
                PMC_OFF_FXPOL: fx_pol_q   <= reg_wdata[NFX-1:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky status; a new event beats the read-clear in the same cycle
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq_status_q <= 8'h00;
        end else if (irqst_rd) begin
            irq_status_q <= ev_set;
        end else begin
            irq_status_q <= irq_status_q | ev_set;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |((irq_status_q | ev_set) & irq_mask_q &
                     ~(irqst_rd ? irq_status_q : 8'h00));
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                PMC_OFF_CTRL:   rdata_q <= system_configuration_register_q;
                PMC_OFF_STATUS: rdata_q <= {8'h00, lp_ref_q, fx_active_any,
                                            nmi_n_sync, reset_input_pin_n_sync,
                                            pend_pd_q, state_q};
                PMC_OFF_IRQST:  rdata_q <= {8'h00, irq_status_q};
                PMC_OFF_MASK:   rdata_q <= {8'h00, irq_mask_q};
                PMC_OFF_FXEN:   rdata_q <= 16'(fx_en_q);
                PMC_OFF_FXPOL:  rdata_q <= 16'(fx_pol_q);
                default:        rdata_q <= 16'h0000;
            endcase
        end else begin
            rdata_q <= 16'h0000;
        end
    end

    assign reg_rdata = rdata_q;
endmodule

// ---- rtl/pmc_sync3.sv ----
// Three-stage synchroniser; output changes once stages two and three agree
module pmc_sync3 #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_sys or posedge rst) begin
                if (rst) begin
                    dout[i] <= 1'b0;
                end else if (s2_q[i] == s3_q[i]) begin
                    dout[i] <= s3_q[i];
                end
            end
        end
    endgenerate
endmodule
